// file: src/rps_pin_select.sv
// module: remappable pin-select registers and their input/output muxes
// Notes on behaviour
// - each input register holds two 8-bit pin selectors, bits 15:8 and 7:0
// - all selector bits are read/write and clear to zero at reset
// - pwm input 15 upper, 14 lower; pwm input 16 lower of next register
// - nibble receiver 1 upper beside pwm 16; receiver 2 lower of next
// - logic cell A upper; C upper, B lower next; D lower after that
// - converter trigger selector sits in bits 15:8 beside logic cell D
// - output registers: 13:8 odd pin function, 5:0 even pin, pins 32-37
// - output register bits 15:14 and 7:6 ignore writes, read as zero
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rps_pin_select
  import rps_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [NUM_PINS-1:0] remappable_pin_in,
  output rps_periph_in_s periph_in_out,
  input wire logic [NUM_FUNCS-1:0] periph_func_in,
  input wire logic [NUM_OUT_PINS-1:0] port_func_in,
  output logic [NUM_OUT_PINS-1:0] remappable_pin_out
);

  // ****************************************************************
  // pin input synchronisers
  // ****************************************************************
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;

  // first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= remappable_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************************************
  // input-select registers
  // ****************************************************************
  rps_in_sel_s in_sel_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_sel_r <= '{default: PIN_SEL_RESET};
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        REG_PWM_IN_15_14: begin
          in_sel_r.pwm_ctl_in15_selector <=
            reg_wdata_in[HI_SEL_LSB +: PIN_W];
          in_sel_r.pwm_ctl_in14_selector <=
            reg_wdata_in[LO_SEL_LSB +: PIN_W];
        end
        // nibble rx1 high, pwm 16 low
        REG_SENT1_PWM16: begin
          in_sel_r.nibble_rx1_selector <=
            reg_wdata_in[HI_SEL_LSB +: PIN_W];
          in_sel_r.pwm_ctl_in16_selector <=
            reg_wdata_in[LO_SEL_LSB +: PIN_W];
        end
        REG_LOGIC_A_SENT2: begin
          in_sel_r.logic_cell_in_a_selector <=
            reg_wdata_in[HI_SEL_LSB +: PIN_W];
          in_sel_r.nibble_rx2_selector <=
            reg_wdata_in[LO_SEL_LSB +: PIN_W];
        end
        REG_LOGIC_C_B: begin
          in_sel_r.logic_cell_in_c_selector <=
            reg_wdata_in[HI_SEL_LSB +: PIN_W];
          in_sel_r.logic_cell_in_b_selector <=
            reg_wdata_in[LO_SEL_LSB +: PIN_W];
        end
        REG_TRIG_LOGIC_D: begin
          in_sel_r.conv_trigger_selector <=
            reg_wdata_in[HI_SEL_LSB +: PIN_W];
          in_sel_r.logic_cell_in_d_selector <=
            reg_wdata_in[LO_SEL_LSB +: PIN_W];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // output-select registers
  // ****************************************************************
  logic [FUNC_W-1:0] func_sel_r [NUM_OUT_PINS];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_OUT_PINS; i++) begin
        func_sel_r[i] <= FUNC_SEL_RESET;
      end
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        REG_PINS_33_32: begin
          func_sel_r[1] <= reg_wdata_in[HI_FUNC_LSB +: FUNC_W];
          func_sel_r[0] <= reg_wdata_in[LO_FUNC_LSB +: FUNC_W];
        end
        REG_PINS_35_34: begin
          func_sel_r[3] <= reg_wdata_in[HI_FUNC_LSB +: FUNC_W];
          func_sel_r[2] <= reg_wdata_in[LO_FUNC_LSB +: FUNC_W];
        end
        REG_PINS_37_36: begin
          func_sel_r[5] <= reg_wdata_in[HI_FUNC_LSB +: FUNC_W];
          func_sel_r[4] <= reg_wdata_in[LO_FUNC_LSB +: FUNC_W];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = UNMAPPED_READ;
    unique case (reg_addr_in)
      REG_PWM_IN_15_14: rdata_nxt = {in_sel_r.pwm_ctl_in15_selector,
                                     in_sel_r.pwm_ctl_in14_selector};
      REG_SENT1_PWM16: rdata_nxt = {in_sel_r.nibble_rx1_selector,
                                    in_sel_r.pwm_ctl_in16_selector};
      REG_LOGIC_A_SENT2: rdata_nxt = {in_sel_r.logic_cell_in_a_selector,
                                      in_sel_r.nibble_rx2_selector};
      REG_LOGIC_C_B: rdata_nxt = {in_sel_r.logic_cell_in_c_selector,
                                  in_sel_r.logic_cell_in_b_selector};
      REG_TRIG_LOGIC_D: rdata_nxt = {in_sel_r.conv_trigger_selector,
                                     in_sel_r.logic_cell_in_d_selector};
      REG_PINS_33_32: rdata_nxt = {2'h0, func_sel_r[1],
                                   2'h0, func_sel_r[0]};
      REG_PINS_35_34: rdata_nxt = {2'h0, func_sel_r[3],
                                   2'h0, func_sel_r[2]};
      REG_PINS_37_36: rdata_nxt = {2'h0, func_sel_r[5],
                                   2'h0, func_sel_r[4]};
      default: rdata_nxt = UNMAPPED_READ;
    endcase
  end

  // data held only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= UNMAPPED_READ;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_nxt;
    end else begin
      reg_rdata_out <= UNMAPPED_READ;
    end
  end

  // ****************************************************************
  // input mux
  // ****************************************************************
  function automatic logic pick_pin(input logic [PIN_W-1:0] sel,
                                    input logic [NUM_PINS-1:0] pins);
    logic v;
    v = 1'b0;
    if (sel != PIN_NONE) begin
      v = pins[sel];
    end
    return v;
  endfunction

  // registered so outputs come from flops
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_in_out <= '0;
    end else begin
      periph_in_out.pwm_ctl_in14 <=
        pick_pin(in_sel_r.pwm_ctl_in14_selector, pin_sync_r);
      periph_in_out.pwm_ctl_in15 <=
        pick_pin(in_sel_r.pwm_ctl_in15_selector, pin_sync_r);
      periph_in_out.pwm_ctl_in16 <=
        pick_pin(in_sel_r.pwm_ctl_in16_selector, pin_sync_r);
      periph_in_out.nibble_rx1 <=
        pick_pin(in_sel_r.nibble_rx1_selector, pin_sync_r);
      periph_in_out.nibble_rx2 <=
        pick_pin(in_sel_r.nibble_rx2_selector, pin_sync_r);
      periph_in_out.logic_cell_in_a <=
        pick_pin(in_sel_r.logic_cell_in_a_selector, pin_sync_r);
      periph_in_out.logic_cell_in_b <=
        pick_pin(in_sel_r.logic_cell_in_b_selector, pin_sync_r);
      periph_in_out.logic_cell_in_c <=
        pick_pin(in_sel_r.logic_cell_in_c_selector, pin_sync_r);
      periph_in_out.logic_cell_in_d <=
        pick_pin(in_sel_r.logic_cell_in_d_selector, pin_sync_r);
      periph_in_out.conv_trigger <=
        pick_pin(in_sel_r.conv_trigger_selector, pin_sync_r);
    end
  end

  // ****************************************************************
  // output mux
  // ****************************************************************
  // function signals share our clock, so no synchroniser here
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      remappable_pin_out <= '0;
    end else begin
      for (int i = 0; i < NUM_OUT_PINS; i++) begin
        if (func_sel_r[i] == FUNC_NONE) begin
          remappable_pin_out[i] <= port_func_in[i];
        end else begin
          remappable_pin_out[i] <= periph_func_in[func_sel_r[i]];
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: src/rps_pkg.sv
// package: register map, field layout and carriers for the pin-select regs
`default_nettype none
package rps_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PIN_W = 8;
  localparam int unsigned FUNC_W = 6;
  localparam int unsigned NUM_PINS = 256;
  localparam int unsigned NUM_FUNCS = 64;
  localparam int unsigned NUM_OUT_PINS = 6;

  // register indices, one per address
  localparam logic [ADDR_W-1:0] REG_PWM_IN_15_14 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SENT1_PWM16 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_LOGIC_A_SENT2 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_LOGIC_C_B = 4'h3;
  localparam logic [ADDR_W-1:0] REG_TRIG_LOGIC_D = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PINS_33_32 = 4'h5;
  localparam logic [ADDR_W-1:0] REG_PINS_35_34 = 4'h6;
  localparam logic [ADDR_W-1:0] REG_PINS_37_36 = 4'h7;

  // field positions
  localparam int unsigned HI_SEL_LSB = 8;
  localparam int unsigned LO_SEL_LSB = 0;
  localparam int unsigned HI_FUNC_LSB = 8;
  localparam int unsigned LO_FUNC_LSB = 0;

  // reset values, unmapped read data and the no-selection codes
  localparam logic [PIN_W-1:0] PIN_SEL_RESET = 8'h00;
  localparam logic [FUNC_W-1:0] FUNC_SEL_RESET = 6'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;
  localparam logic [PIN_W-1:0] PIN_NONE = 8'h00;
  localparam logic [FUNC_W-1:0] FUNC_NONE = 6'h00;

  typedef struct packed {
    logic [PIN_W-1:0] pwm_ctl_in14_selector;
    logic [PIN_W-1:0] pwm_ctl_in15_selector;
    logic [PIN_W-1:0] pwm_ctl_in16_selector;
    logic [PIN_W-1:0] nibble_rx1_selector;
    logic [PIN_W-1:0] nibble_rx2_selector;
    logic [PIN_W-1:0] logic_cell_in_a_selector;
    logic [PIN_W-1:0] logic_cell_in_b_selector;
    logic [PIN_W-1:0] logic_cell_in_c_selector;
    logic [PIN_W-1:0] logic_cell_in_d_selector;
    logic [PIN_W-1:0] conv_trigger_selector;
  } rps_in_sel_s;

  typedef struct packed {
    logic pwm_ctl_in14;
    logic pwm_ctl_in15;
    logic pwm_ctl_in16;
    logic nibble_rx1;
    logic nibble_rx2;
    logic logic_cell_in_a;
    logic logic_cell_in_b;
    logic logic_cell_in_c;
    logic logic_cell_in_d;
    logic conv_trigger;
  } rps_periph_in_s;

endpackage

`default_nettype wire

// file: testbench/rps_pin_select_sva.sv
// checker: port-level assertions for the pin-select register block
`timescale 1ns/1ps
`default_nettype none
module rps_pin_select_sva
  import rps_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [NUM_PINS-1:0] remappable_pin_in,
  input wire rps_periph_in_s periph_in_out,
  input wire logic [NUM_FUNCS-1:0] periph_func_in,
  input wire logic [NUM_OUT_PINS-1:0] port_func_in,
  input wire logic [NUM_OUT_PINS-1:0] remappable_pin_out
);
  // ****************************************
  // shadow of two fields, not the whole map
  // ****************************************
  logic seen_r;
  logic [5:0] s32_r;
  logic [7:0] s14_r;
  logic e32;
  logic e14;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_r <= 1'b0;
      s32_r <= 6'h00;
      s14_r <= 8'h00;
    end else if (reg_wr_in) begin
      seen_r <= 1'b1;
      if (reg_addr_in == 4'h5) begin
        s32_r <= reg_wdata_in[5:0];
      end
      if (reg_addr_in == 4'h0) begin
        s14_r <= reg_wdata_in[7:0];
      end
    end
  end
  // zero selector: port function, idle input
  assign e32 = (s32_r == 6'h00) ? port_func_in[0] : periph_func_in[s32_r];
  assign e14 = (s14_r != 8'h00) && remappable_pin_in[s14_r];
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_sel_readback: assert property (
    (reg_wr_in && reg_addr_in < 4'h5) ##1 (reg_rd_in && $stable(reg_addr_in))
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("sel readback");
  chk_out_readback: assert property (
    (reg_wr_in && reg_addr_in inside {[4'h5:4'h7]}) ##1
    (reg_rd_in && $stable(reg_addr_in)) |=>
    reg_rdata_out == ($past(reg_wdata_in, 2) & 16'h3F3F))
    else $error("out readback");
  chk_out_reserved: assert property (
    reg_rd_in && reg_addr_in inside {[4'h5:4'h7]} |=>
    reg_rdata_out[15:14] == 2'h0 && reg_rdata_out[7:6] == 2'h0)
    else $error("reserved bits set");
  chk_reset_zero: assert property (
    !seen_r && reg_rd_in |=> reg_rdata_out == 16'h0000)
    else $error("reset value");
  chk_periph_idle: assert property (
    !seen_r |-> periph_in_out == '0) else $error("idle input");
  chk_pin_default: assert property (
    !seen_r && !reg_wr_in |=> remappable_pin_out == $past(port_func_in))
    else $error("pin default");
  chk_pin32_route: assert property (
    !reg_wr_in |=> remappable_pin_out[0] == $past(e32))
    else $error("pin32 route");
  chk_pwm14_route: assert property (
    $stable(remappable_pin_in)[*3] ##0 !reg_wr_in |=>
    periph_in_out.pwm_ctl_in14 == $past(e14)) else $error("pwm14 route");
endmodule
bind rps_pin_select rps_pin_select_sva u_sva (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .remappable_pin_in(remappable_pin_in),
  .periph_in_out(periph_in_out), .periph_func_in(periph_func_in),
  .port_func_in(port_func_in), .remappable_pin_out(remappable_pin_out));
`default_nettype wire

// file: testbench/testbench.sv
// testbench: self-checking bench for the pin-select register block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rps_pkg::*;
;
  logic core_clk_in;
  logic rst_n_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [DATA_W-1:0] reg_rdata_out;
  logic [NUM_PINS-1:0] remappable_pin_in;
  rps_periph_in_s periph_in_out;
  logic [NUM_FUNCS-1:0] periph_func_in;
  logic [NUM_OUT_PINS-1:0] port_func_in;
  logic [NUM_OUT_PINS-1:0] remappable_pin_out;
  logic [15:0] q;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // struct bit of each field, hi byte first per register
  int fbit [10] = '{8, 9, 6, 7, 4, 5, 2, 3, 0, 1};
  rps_pin_select DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .remappable_pin_in(remappable_pin_in),
    .periph_in_out(periph_in_out), .periph_func_in(periph_func_in),
    .port_func_in(port_func_in), .remappable_pin_out(remappable_pin_out));
  // ****************************************
  // clock, timeout and verdict
  // ****************************************
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  task complete_run;
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // whole run needs well under 2000 cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_sig(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus tasks start and end in the time step of a rising edge
  task wreg(input logic [3:0] a, input logic [15:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  // optional write, then a read in the very next cycle
  task acc(input bit w, input logic [3:0] a, input logic [15:0] d);
    if (w) begin
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
    end
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    q = reg_rdata_out;
    @(posedge core_clk_in);
  endtask
  // long settle: two sync stages plus output flop
  task settle;
    repeat (4) @(posedge core_clk_in);
    @(negedge core_clk_in);
  endtask
  task t_regs;
    for (int a = 0; a < 8; a++) begin
      acc(0, a[3:0], 16'h0000);
      cmp_reg(q, 16'h0000);
    end
    for (int a = 0; a < 9; a++) begin
      acc(1, a[3:0], 16'hFFFF);
      cmp_reg(q, a < 5 ? 16'hFFFF : a < 8 ? 16'h3F3F : 16'h0000);
      acc(1, a[3:0], 16'hA5C3);
      cmp_reg(q, a < 5 ? 16'hA5C3 : a < 8 ? 16'h2503 : 16'h0000);
      wreg(a[3:0], 16'h0000);
    end
  endtask
  task t_inputs;
    for (int i = 0; i < 10; i++) begin
      wreg(4'(i / 2), i % 2 ? 16'h00C5 : 16'hC500);
      remappable_pin_in[8'hC5] <= 1'b1;
      settle();
      cmp_sig({6'h00, periph_in_out}, 16'h1 << fbit[i]);
      @(posedge core_clk_in);
      remappable_pin_in[8'hC5] <= 1'b0;
      settle();
      cmp_sig({6'h00, periph_in_out}, 16'h0000); // idle input
      @(posedge core_clk_in);
      wreg(4'(i / 2), 16'h0000);
    end
  endtask
  task t_outputs;
    settle();
    cmp_sig({10'h000, remappable_pin_out}, 16'h002A);
    for (int j = 0; j < 6; j++) begin
      @(posedge core_clk_in);
      wreg(4'(5 + j / 2), j % 2 ? 16'h2D00 : 16'h002D);
      periph_func_in[45] <= 1'b1;
      settle();
      cmp_sig({10'h000, remappable_pin_out}, 16'h2A | (16'h1 << j));
      @(posedge core_clk_in);
      periph_func_in[45] <= 1'b0;
      settle();
      cmp_sig({10'h000, remappable_pin_out}, 16'h2A & ~(16'h1 << j));
      @(posedge core_clk_in);
      wreg(4'(5 + j / 2), 16'h0000);
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    reg_addr_in = 4'h0;
    reg_wdata_in = 16'h0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    remappable_pin_in = 256'h1;
    periph_func_in = 64'h1;
    port_func_in = 6'h2A;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    t_regs();
    t_inputs();
    t_outputs();
    complete_run();
  end
endmodule
`default_nettype wire
